// *** inc/ufr_pkg.sv ***
// Constants shared by the raise/lower and pulse-train frequency reference block
package ufr_pkg;
    // Main frequency source codes
    localparam logic [3:0]  SRC_UPDOWN      = 4'h7;
    localparam logic [3:0]  SRC_PULSE       = 4'hc;
    // Terminal function codes for raise and lower
    localparam logic [4:0]  FUNC_RAISE      = 5'h11;
    localparam logic [4:0]  FUNC_LOWER      = 5'h12;
    localparam int          NUM_TERMS       = 9;
    // Previous-source classes seen when raise/lower takes over
    localparam logic [1:0]  PREV_MAIN_SEC   = 2'h0;
    localparam logic [1:0]  PREV_PID        = 2'h1;
    localparam logic [1:0]  PREV_STEP_COMM  = 2'h2;
    // Frequency is carried in 0.01 Hz units; maximum setting in 0.1 Hz units
    localparam logic [15:0] FREQ_RESET      = 16'h0000;
    localparam logic [12:0] MAX_SET_MIN     = 13'h00fa;   // 25.0 Hz
    localparam logic [12:0] MAX_SET_MAX     = 13'h1388;   // 500.0 Hz
    localparam logic [3:0]  MAX_TO_FREQ     = 4'ha;       // 0.1 Hz to 0.01 Hz
    localparam logic [6:0]  PULSE_SCALE     = 7'h64;      // Hz to 0.01 Hz
    // Control cycle: one update per millisecond
    localparam int          CLK_FREQ_HZ     = 20_000_000;
    localparam int          CTRL_PERIOD_US  = 1000;
    localparam int          CTRL_CYCLES     = CLK_FREQ_HZ / 1_000_000 * CTRL_PERIOD_US;
endpackage

// *** rtl/ufr_freq_ref.sv ***
// Raise/lower and sign-plus-pulse frequency reference generator
// Summary of operation
// - Raise/lower works only with source select 7, raise/lower taken from terminals coded 17/18.
// - During a run under raise/lower the frequency stays within 0 Hz and the maximum frequency.
// - Raise alone ramps the frequency up at the acceleration rate.
// - Lower alone ramps the frequency down at the deceleration rate.
// - Outside the restart ramp, neither or both of raise and lower hold the frequency.
// - Start mode 0 clears the raise/lower frequency at every restart and power-up.
// - Start mode 1 keeps the last reached frequency and reapplies it at the next restart.
// - A raise or lower during the restart ramp saves the present frequency and continues from it.
// - Switching from another main or secondary source starts from that source's reference.
// - Taking over from a cancelled PID starts from the PID output.
// - From multi-step or link: mode 0 uses that reference, mode 1 the retained frequency.
// - Pulse-train setting works with source select 12, fed with a sign and a pulse stream.
// - Pulse reference in Hz is the kilopulse rate times numerator over denominator.
// - Sign and run command together choose forward or reverse rotation.
// - The pulse reference is smoothed by a programmable time constant.
// - The maximum frequency is settable from 25.0 to 500.0 Hz in 0.1 Hz steps.
`timescale 1ns/1ps
module ufr_freq_ref
    import ufr_pkg::*;
#(
    parameter int CTRL_TICK_CYCLES = CTRL_CYCLES     // Control cycle length in clocks
) (
    input  wire logic        clk_i,                  // 20 MHz clock
    input  wire logic        rst_i,                  // Synchronous reset, active high
    input  wire logic [8:0]  term_in_i,              // Digital input terminals (pins)
    input  wire logic [44:0] term_func_i,            // Function code per terminal, 5 bits each
    input  wire logic        run_forward_cmd_i,      // Forward run command (pin)
    input  wire logic        run_reverse_cmd_i,      // Reverse run command (pin)
    input  wire logic        pulse_in_i,             // Pulse train (pin)
    input  wire logic        pulse_sign_i,           // Pulse polarity, high = negative (pin)
    input  wire logic [3:0]  main_src_sel_i,         // Main frequency source select
    input  wire logic [1:0]  prev_src_kind_i,        // Class of source being left
    input  wire logic [15:0] prev_ref_i,             // Reference of source being left
    input  wire logic [15:0] pid_out_i,              // PID controller output
    input  wire logic        start_mode_i,           // 0: start from zero, 1: retained
    input  wire logic [15:0] accel_rate_i,           // Raise step per control cycle
    input  wire logic [15:0] decel_rate_i,           // Lower step per control cycle
    input  wire logic [12:0] max_freq_i,             // Maximum frequency, 0.1 Hz
    input  wire logic [15:0] pulse_num_i,            // Numerator scale factor
    input  wire logic [15:0] pulse_den_i,            // Denominator scale factor
    input  wire logic [15:0] filt_tc_i,              // Filter time constant, control cycles
    output logic      [15:0] freq_ref_o,             // Frequency reference, 0.01 Hz
    output logic             dir_reverse_o,          // Reverse rotation requested
    output logic             updown_active_o,        // Raise/lower source in use
    output logic             pulse_active_o          // Pulse-train source in use
);
    logic [12:0] pin_s1;
    logic [12:0] pin_s2;
    logic        pulse_prev;
    logic [31:0] tick_cnt;
    logic        tick;
    logic        raise_cmd;
    logic        lower_cmd;
    logic        run_on;
    logic        run_prev;
    logic [3:0]  src_prev;
    logic [12:0] max_set;
    logic [16:0] max_freq;
    logic [15:0] ud_freq;
    logic [15:0] retained;
    logic        restoring;
    logic [16:0] next_ud;
    logic [15:0] pulse_cnt;
    logic [15:0] pulse_rate;
    logic [15:0] pulse_ref;
    logic [15:0] filt;
    logic [38:0] prod;
    logic [17:0] diff;
    logic [15:0] entry_ref;
    logic        pulse_rise;

    // Two-flop synchronisers; pins are asynchronous to clk_i
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1 <= 13'h0000;
            pin_s2 <= 13'h0000;
        end else begin
            pin_s1 <= {pulse_sign_i, pulse_in_i, run_reverse_cmd_i, run_forward_cmd_i, term_in_i};
            pin_s2 <= pin_s1;
        end
    end

    // Raise/lower from whichever terminals carry codes 17/18
    always_comb begin
        raise_cmd = 1'b0;
        lower_cmd = 1'b0;
        for (int i = 0; i < NUM_TERMS; i++) begin
            if (term_func_i[i*5 +: 5] == FUNC_RAISE && pin_s2[i]) begin
                raise_cmd = 1'b1;
            end
            if (term_func_i[i*5 +: 5] == FUNC_LOWER && pin_s2[i]) begin
                lower_cmd = 1'b1;
            end
        end
    end

    assign run_on = pin_s2[9] | pin_s2[10];

    // Maximum setting held inside its settable span
    always_comb begin
        if (max_freq_i < MAX_SET_MIN) begin
            max_set = MAX_SET_MIN;
        end else if (max_freq_i > MAX_SET_MAX) begin
            max_set = MAX_SET_MAX;
        end else begin
            max_set = max_freq_i;
        end
        max_freq = 17'(max_set * MAX_TO_FREQ);
    end

    // Control cycle timebase
    always_ff @(posedge clk_i) begin
        if (rst_i || tick_cnt == 32'(CTRL_TICK_CYCLES - 1)) begin
            tick_cnt <= 32'h0000_0000;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
        end
    end
    assign tick = (tick_cnt == 32'(CTRL_TICK_CYCLES - 1));

    // Edge history for run and source switching
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_prev <= 1'b0;
            src_prev <= 4'h0;
        end else begin
            run_prev <= run_on;
            src_prev <= main_src_sel_i;
        end
    end

    // Candidate ramp value, one step per control cycle
    always_comb begin
        next_ud = {1'b0, ud_freq};
        if (raise_cmd && !lower_cmd) begin
            next_ud = {1'b0, ud_freq} + {1'b0, accel_rate_i};
        end else if (lower_cmd && !raise_cmd) begin
            if (ud_freq > decel_rate_i) begin
                next_ud = {1'b0, ud_freq - decel_rate_i};
            end else begin
                next_ud = 17'h00000;
            end
        end else if (restoring) begin
            next_ud = {1'b0, ud_freq} + {1'b0, accel_rate_i};
            if (next_ud > {1'b0, retained}) begin
                next_ud = {1'b0, retained};
            end
        end
        if (next_ud > max_freq) begin
            next_ud = max_freq;
        end
    end

    // Start value on take-over; a source above the maximum is cut so the ramp starts in range
    always_comb begin
        unique case (prev_src_kind_i)
            PREV_PID:       entry_ref = pid_out_i;
            PREV_STEP_COMM: entry_ref = start_mode_i ? retained : prev_ref_i;
            default:        entry_ref = prev_ref_i;
        endcase
        if ({1'b0, entry_ref} > max_freq) begin
            entry_ref = max_freq[15:0];
        end
    end

    // Raise/lower frequency, retained value and restart ramp
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ud_freq   <= FREQ_RESET;
            retained  <= FREQ_RESET;
            restoring <= 1'b0;
        end else if (main_src_sel_i == SRC_UPDOWN && src_prev != SRC_UPDOWN) begin
            restoring <= 1'b0;
            ud_freq   <= entry_ref;
        end else if (main_src_sel_i == SRC_UPDOWN && run_on && !run_prev) begin
            // Restart always ramps from zero; mode 1 heads back for the retained value
            ud_freq   <= FREQ_RESET;
            restoring <= start_mode_i && retained != FREQ_RESET;
        end else if (main_src_sel_i == SRC_UPDOWN && run_on && tick) begin
            ud_freq <= next_ud[15:0];
            if (raise_cmd != lower_cmd) begin
                restoring <= 1'b0;
                retained  <= next_ud[15:0];
            end else if (restoring) begin
                restoring <= next_ud[15:0] != retained;
            end else begin
                retained  <= next_ud[15:0];
            end
        end else if ({1'b0, ud_freq} > max_freq) begin
            ud_freq <= max_freq[15:0];
        end
    end

    // Rising edge of the synchronised pulse pin
    assign pulse_rise = pin_s2[11] && !pulse_prev;

    // Pulses counted per control cycle give kilopulses per second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_prev <= 1'b0;
            pulse_cnt  <= 16'h0000;
            pulse_rate <= 16'h0000;
        end else begin
            pulse_prev <= pin_s2[11];
            if (tick) begin
                pulse_rate <= pulse_cnt;
                // An edge on the tick itself opens the next window, so none is lost
                pulse_cnt  <= {15'h0000, pulse_rise};
            end else if (pulse_rise && pulse_cnt != 16'hffff) begin
                pulse_cnt <= pulse_cnt + 16'h0001;
            end
        end
    end

    // Scaling; a zero denominator gives no reference rather than a fault
    always_comb begin
        prod = 39'(pulse_rate * pulse_num_i * PULSE_SCALE);
        if (pulse_den_i == 16'h0000) begin
            pulse_ref = 16'h0000;
        end else if (prod / 39'(pulse_den_i) > 39'(max_freq)) begin
            pulse_ref = max_freq[15:0];
        end else begin
            pulse_ref = 16'(prod / 39'(pulse_den_i));
        end
        diff = 18'({2'b00, pulse_ref} - {2'b00, filt});
    end

    // First-order low-pass; a setting of 0 or 1 passes the input straight through
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt <= 16'h0000;
        end else if (tick) begin
            if (filt_tc_i <= 16'h0001) begin
                filt <= pulse_ref;
            end else begin
                filt <= 16'($signed({2'b00, filt}) + $signed(diff) / $signed({2'b00, filt_tc_i}));
            end
        end
    end

    // Outputs by source select; other sources give no reference from this block
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            freq_ref_o      <= 16'h0000;
            dir_reverse_o   <= 1'b0;
            updown_active_o <= 1'b0;
            pulse_active_o  <= 1'b0;
        end else begin
            updown_active_o <= main_src_sel_i == SRC_UPDOWN;
            pulse_active_o  <= main_src_sel_i == SRC_PULSE;
            if (main_src_sel_i == SRC_UPDOWN) begin
                freq_ref_o    <= ud_freq;
                dir_reverse_o <= pin_s2[10] && !pin_s2[9];
            end else if (main_src_sel_i == SRC_PULSE) begin
                freq_ref_o    <= filt;
                dir_reverse_o <= pin_s2[12] ? pin_s2[9] : pin_s2[10];
            end else begin
                freq_ref_o    <= 16'h0000;
                dir_reverse_o <= 1'b0;
            end
        end
    end

    // Checks next to the logic they guard
    chk_updown_max_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        {1'b0, ud_freq} <= $past(max_freq) || $past(main_src_sel_i) != SRC_UPDOWN)
        else $error("raise/lower frequency above maximum");
    chk_raise_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && run_on && run_prev && main_src_sel_i == SRC_UPDOWN && src_prev == SRC_UPDOWN
         && raise_cmd && !lower_cmd && {1'b0, ud_freq} + {1'b0, accel_rate_i} <= max_freq)
        |=> ud_freq == $past(ud_freq) + $past(accel_rate_i))
        else $error("raise did not step by acceleration rate");
    chk_lower_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && run_on && run_prev && main_src_sel_i == SRC_UPDOWN && src_prev == SRC_UPDOWN
         && lower_cmd && !raise_cmd && ud_freq >= decel_rate_i && {1'b0, ud_freq} <= max_freq)
        |=> ud_freq == $past(ud_freq) - $past(decel_rate_i))
        else $error("lower did not step by deceleration rate");
    chk_hold_both: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && run_on && run_prev && !restoring && main_src_sel_i == SRC_UPDOWN
         && src_prev == SRC_UPDOWN && raise_cmd == lower_cmd && {1'b0, ud_freq} <= max_freq)
        |=> $stable(ud_freq))
        else $error("frequency moved while holding");
    chk_restart_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (main_src_sel_i == SRC_UPDOWN && src_prev == SRC_UPDOWN && run_on && !run_prev)
        |=> ud_freq == 16'h0000 ##1 (freq_ref_o == 16'h0000 || !updown_active_o))
        else $error("restart did not clear raise/lower frequency");
    chk_pid_takeover: assert property (@(posedge clk_i) disable iff (rst_i)
        (main_src_sel_i == SRC_UPDOWN && src_prev != SRC_UPDOWN && prev_src_kind_i == PREV_PID
         && {1'b0, pid_out_i} <= max_freq)
        |=> ud_freq == $past(pid_out_i))
        else $error("PID takeover did not load PID output");
    chk_pulse_dir: assert property (@(posedge clk_i) disable iff (rst_i)
        (main_src_sel_i == SRC_PULSE && pin_s2[9] && !pin_s2[10])
        |=> dir_reverse_o == $past(pin_s2[12]))
        else $error("pulse direction wrong for forward command");
    chk_filter_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && filt_tc_i > 16'h0001 && pulse_ref >= filt)
        |=> filt >= $past(filt) && filt <= $past(pulse_ref))
        else $error("filter output left its bounds");
    chk_restore_break: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && run_on && run_prev && restoring && main_src_sel_i == SRC_UPDOWN
         && src_prev == SRC_UPDOWN && raise_cmd != lower_cmd)
        |=> !restoring && retained == ud_freq)
        else $error("command during restart did not take over the retained value");
    chk_step_retained: assert property (@(posedge clk_i) disable iff (rst_i)
        (main_src_sel_i == SRC_UPDOWN && src_prev != SRC_UPDOWN && start_mode_i
         && prev_src_kind_i == PREV_STEP_COMM && {1'b0, retained} <= max_freq)
        |=> ud_freq == $past(retained))
        else $error("multi-step takeover did not load retained frequency");
endmodule

// *** dv/ufr_far_side.sv ***
// Far-side controller model: terminal switches, run commands, sign-plus-pulse source
`timescale 1ns/1ps
module ufr_far_side (
    input  wire logic       clk_i,             // Bench clock
    input  wire logic       raise_i,           // Close the raise switch
    input  wire logic       lower_i,           // Close the lower switch
    input  wire logic       fwd_i,             // Forward run request
    input  wire logic       rev_i,             // Reverse run request
    input  wire logic       neg_i,             // Negative polarity wanted
    input  wire logic       pulse_en_i,        // Pulse source running
    output logic      [8:0] term_in_o,         // Terminal pins
    output logic            run_forward_cmd_o, // Forward run pin
    output logic            run_reverse_cmd_o, // Reverse run pin
    output logic            pulse_o,           // Pulse pin
    output logic            sign_o             // Sign pin
);
    logic [1:0] phase;

    // Pins start idle so the block never sees an unknown level
    initial begin
        term_in_o = 9'h000;
        run_forward_cmd_o = 1'b0;
        run_reverse_cmd_o = 1'b0;
        pulse_o = 1'b0;
        sign_o = 1'b0;
        phase = 2'h0;
    end

    // Raise on terminal 2, lower on terminal 5; open switches read low
    always @(posedge clk_i) begin
        term_in_o <= {3'h0, lower_i, 2'h0, raise_i, 2'h0};
        run_forward_cmd_o <= fwd_i;
        run_reverse_cmd_o <= rev_i;
    end

    // Four-clock pulse period; line rests low when the source stops
    always @(posedge clk_i) begin
        phase <= pulse_en_i ? phase + 2'h1 : 2'h0;
        pulse_o <= pulse_en_i & phase[1];
        sign_o <= neg_i;
    end
endmodule

// *** dv/ufr_freq_ref_bench.sv ***
// Self-checking bench for the raise/lower and pulse-train frequency reference
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("BAD %0t got %0h expected %0h", $time, got, exp); \
    end \
end
module ufr_freq_ref_bench
    import ufr_pkg::*;
;
    localparam int          TICK  = 20;
    localparam logic [15:0] ACC   = 16'h01f4;
    localparam logic [15:0] DEC   = 16'h02bc;
    localparam logic [15:0] TOP   = 16'(MAX_SET_MIN * MAX_TO_FREQ);
    localparam logic [44:0] FUNCS = {15'h0, FUNC_LOWER, 10'h0, FUNC_RAISE, 10'h0};
    logic        clk_i, rst_i, raise, lower, fwd, rev, neg, pen, mode;
    logic        fwd_pin, rev_pin, pulse, sign, dir, ud_act, p_act;
    logic [8:0]  term_in;
    logic [44:0] tfunc;
    logic [3:0]  src;
    logic [1:0]  kind;
    logic [15:0] pref, pid, num, tc, freq, v;
    int          mismatches, checks, cyc;

    ufr_far_side ufr_far_side_inst (.clk_i(clk_i), .raise_i(raise), .lower_i(lower),
        .fwd_i(fwd), .rev_i(rev), .neg_i(neg), .pulse_en_i(pen), .term_in_o(term_in),
        .run_forward_cmd_o(fwd_pin), .run_reverse_cmd_o(rev_pin), .pulse_o(pulse),
        .sign_o(sign));
    // Short control cycle keeps the ramps quick
    ufr_freq_ref #(.CTRL_TICK_CYCLES(TICK)) ufr_freq_ref_inst (.clk_i(clk_i), .rst_i(rst_i),
        .term_in_i(term_in), .term_func_i(tfunc), .run_forward_cmd_i(fwd_pin),
        .run_reverse_cmd_i(rev_pin), .pulse_in_i(pulse), .pulse_sign_i(sign),
        .main_src_sel_i(src), .prev_src_kind_i(kind), .prev_ref_i(pref), .pid_out_i(pid),
        .start_mode_i(mode), .accel_rate_i(ACC), .decel_rate_i(DEC),
        .max_freq_i(MAX_SET_MIN), .pulse_num_i(num), .pulse_den_i(16'h0002),
        .filt_tc_i(tc), .freq_ref_o(freq), .dir_reverse_o(dir),
        .updown_active_o(ud_act), .pulse_active_o(p_act));

    // 20 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task end_sim;
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard, well beyond the whole sequence
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            end_sim;
        end
    end

    // Ends on a falling edge so outputs are settled when read
    task ticks(input int n);
        repeat (n * TICK) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // Bounded wait for the next reference change
    task wait_change(output logic [15:0] val);
        logic [15:0] old;
        int n;
        old = freq;
        n = 0;
        while (freq === old && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 200) `CHK(1'b0, 1'b1)
        val = freq;
    endtask

    task t_refuse;
        @(posedge clk_i);
        src <= SRC_UPDOWN;
        fwd <= 1'b1;
        tfunc <= 45'h0;
        raise <= 1'b1;
        ticks(4);
        `CHK(freq, 16'h0000)
        `CHK(ud_act, 1'b1)
        @(posedge clk_i);
        raise <= 1'b0;
        tfunc <= FUNCS;
        ticks(1);
    endtask

    task t_ramp;
        @(posedge clk_i);
        raise <= 1'b1;
        wait_change(v);
        `CHK(v, ACC)
        ticks(6);
        `CHK(freq, TOP)
        @(posedge clk_i);
        lower <= 1'b1;
        ticks(3);
        `CHK(freq, TOP)
        @(posedge clk_i);
        raise <= 1'b0;
        wait_change(v);
        `CHK(v, TOP - DEC)
        ticks(5);
        `CHK(freq, 16'h0000)
        @(posedge clk_i);
        lower <= 1'b0;
        ticks(3);
        `CHK(freq, 16'h0000)
    endtask

    // Run is dropped and raised again with src held at raise/lower
    task t_restart(input logic m, input int up, input logic [15:0] exp);
        @(posedge clk_i);
        raise <= 1'b1;
        ticks(up);
        @(posedge clk_i);
        raise <= 1'b0;
        mode <= m;
        fwd <= 1'b0;
        ticks(2);
        @(posedge clk_i);
        fwd <= 1'b1;
        ticks(8);
        `CHK(freq, exp)
    endtask

    // Restore ramp after restart cut short by a lower command, then back to the top
    task t_resume;
        @(posedge clk_i);
        fwd <= 1'b0;
        ticks(2);
        @(posedge clk_i);
        fwd <= 1'b1;
        ticks(2);
        @(posedge clk_i);
        lower <= 1'b1;
        ticks(1);
        @(posedge clk_i);
        lower <= 1'b0;
        ticks(1);
        v = freq;
        ticks(4);
        `CHK(freq, v)
        `CHK(v < TOP, 1'b1)
        @(posedge clk_i);
        raise <= 1'b1;
        ticks(6);
        `CHK(freq, TOP)
        @(posedge clk_i);
        raise <= 1'b0;
        ticks(1);
    endtask

    task t_switch(input logic [1:0] k, input logic m, input logic [15:0] p,
                  input logic [15:0] exp);
        @(posedge clk_i);
        src <= 4'h0;
        ticks(2);
        `CHK(freq, 16'h0000)
        @(posedge clk_i);
        kind <= k;
        mode <= m;
        pref <= p;
        pid <= 16'h0309;
        src <= SRC_UPDOWN;
        ticks(2);
        `CHK(freq, exp)
    endtask

    task t_pulse;
        @(posedge clk_i);
        src <= SRC_PULSE;
        pen <= 1'b1;
        ticks(6);
        `CHK(freq, 16'(5 * 3 * PULSE_SCALE / 2))
        `CHK(p_act, 1'b1)
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            neg <= i[1];
            fwd <= ~i[0];
            rev <= i[0];
            ticks(2);
            `CHK(dir, i[1] ^ i[0])
        end
        @(posedge clk_i);
        neg <= 1'b0;
        fwd <= 1'b1;
        rev <= 1'b0;
        ticks(3);
        @(posedge clk_i);
        tc <= 16'h0004;
        num <= 16'h0006;
        wait_change(v);
        `CHK((v > 16'd750) && (v < 16'd1500), 1'b1)
    endtask

    // Main sequence
    initial begin
        {raise, lower, fwd, rev, neg, pen, mode} = 7'h00;
        mismatches = 0;
        checks = 0;
        cyc = 0;
        rst_i = 1'b1;
        tfunc = FUNCS;
        src = 4'h0;
        kind = PREV_MAIN_SEC;
        pref = 16'h0000;
        pid = 16'h0000;
        tc = 16'h0000;
        num = 16'h0003;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        `CHK(freq, 16'h0000)
        t_refuse;
        t_ramp;
        t_restart(1'b0, 3, 16'h0000);
        t_restart(1'b1, 7, TOP);
        t_resume;
        t_switch(PREV_STEP_COMM, 1'b1, 16'h0457, TOP);
        t_switch(PREV_STEP_COMM, 1'b0, 16'h0457, 16'h0457);
        t_switch(PREV_MAIN_SEC, 1'b1, 16'h04d2, 16'h04d2);
        t_switch(PREV_PID, 1'b0, 16'h04d2, 16'h0309);
        t_pulse;
        end_sim;
    end
endmodule
